// ### src/phase_seq_pkg.sv
// Constants, register map and carrier types for the phase sequencer
package phase_seq_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MIN_SET_GAP_NS = 50;
  localparam int MIN_SET_GAP_CYC = (MIN_SET_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOKEN_PULSE_NS = 100;
  localparam int TOKEN_PULSE_CYC = (TOKEN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_RISE_NS = 200;
  localparam int RAMP_RISE_CYC = (RAMP_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS_BASE_MS = 1;
  localparam int SS_BASE_CYC = SS_BASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [2:0] SS_MAX_CODE = 3'h4;
  localparam int MAX_PHASES = 6;
  // Register command codes
  localparam logic [7:0] REG_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] REG_VOUT_SCALE_LOOP = 8'h29;
  localparam logic [7:0] REG_SOFT_START_TIME = 8'h61;
  localparam logic [7:0] REG_RAMP_AMPLITUDE_SELECT = 8'hD0;
  localparam logic [7:0] REG_VALLEY_CURRENT_LIMIT = 8'hD7;
  localparam logic [7:0] REG_OPERATION_MODE = 8'hE0;
  // Field positions
  localparam int RAMP_AMP_LSB = 1;
  localparam int SS_CODE_LSB = 0;
  localparam int MODE_SKIP_BIT = 0;
  localparam int MODE_FREQ_LSB = 1;
  localparam int GAIN_FRAC_BITS = 10;
  // Reset values
  localparam logic [15:0] SOFT_START_RST = 16'h0000;
  localparam logic [7:0] RAMP_AMP_RST = 8'h00;
  localparam logic [7:0] VALLEY_LIMIT_RST = 8'h80;
  localparam logic [7:0] OPERATION_MODE_RST = 8'h00;
  localparam logic [15:0] VOUT_COMMAND_RST = 16'h0258;
  localparam logic [15:0] VOUT_SCALE_RST = 16'h0400;
  // Reference in millivolts
  localparam logic [9:0] REF_DEFAULT_MV = 10'h258;
  localparam logic [9:0] REF_MIN_MV = 10'h1F4;
  localparam logic [9:0] REF_MAX_MV = 10'h2A0;

  typedef enum logic [2:0] {
    ST_OFF, ST_PREBIAS, ST_SOFTSTART, ST_RUN, ST_FAULT, ST_DISCHARGE
  } run_state_t;

  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } bus_cmd_t;

  typedef struct packed {
    logic refused;
    logic [15:0] data;
  } bus_rsp_t;
endpackage

// ### src/multiphase_on_time_sequencer.sv
// One phase of a ring of constant-on-time buck phases: token, trigger, on-time, start and stop
module multiphase_on_time_sequencer
  import phase_seq_pkg::*;
#(
  parameter int SS_BASE_CYCLES = SS_BASE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Ring link
  input wire logic token_in_i,
  output logic token_out_o,
  input wire logic set_in_i,
  output logic set_out_o,
  // Analog comparators and sense
  input wire logic trig_cmp_i,
  input wire logic ref_above_fb_i,
  input wire logic fb_below_tenth_i,
  input wire logic zero_cross_i,
  input wire logic [7:0] on_time_base_i,
  input wire logic [7:0] phase_current_i,
  input wire logic [10:0] total_current_i,
  input wire logic [2:0] phase_count_i,
  input wire logic local_fault_i,
  input wire logic ctrl_en_i,
  // Power-good open-drain line
  input wire logic power_good_line_i,
  output logic power_good_line_o,
  output logic power_good_line_oe_o,
  // Switch drives
  output logic high_side_switch_o,
  output logic low_side_switch_o,
  output logic discharge_o,
  output logic ramp_rise_o,
  // Configuration towards the analog side
  output logic [2:0] ramp_amp_o,
  output logic [7:0] valley_limit_o,
  output logic pulse_skip_o,
  output logic [1:0] freq_sel_o,
  output logic [9:0] ref_mv_o,
  output logic is_master_o,
  // Management command port
  input wire logic cmd_valid_i,
  input wire bus_cmd_t cmd_i,
  output logic rsp_valid_o,
  output bus_rsp_t rsp_o
);
  function automatic logic code_known(input logic [7:0] c);
    code_known = (c == REG_VOUT_COMMAND) || (c == REG_VOUT_SCALE_LOOP) ||
      (c == REG_SOFT_START_TIME) || (c == REG_RAMP_AMPLITUDE_SELECT) ||
      (c == REG_VALLEY_CURRENT_LIMIT) || (c == REG_OPERATION_MODE);
  endfunction

  run_state_t state_reg, state_next;
  logic role_taken_reg, master_reg, armed_reg, token_prev_reg, trig_prev_reg;
  logic hs_reg, ls_reg, dis_reg, set_reg, pg_oe_reg, rsp_valid_reg;
  logic tok_reg, ramp_reg;
  logic [7:0] on_cnt_reg;
  logic [1:0] tok_cnt_reg;
  logic [3:0] ramp_cnt_reg;
  logic [1:0] gap_cnt_reg;
  logic [19:0] ss_cnt_reg;
  logic [15:0] ss_time_reg, vout_cmd_reg, vout_scale_reg;
  logic [7:0] ramp_sel_reg, valley_reg, mode_reg;
  logic [9:0] ref_reg;
  bus_rsp_t rsp_reg;

  // Decode
  wire token_fall = token_prev_reg & ~token_in_i;
  wire running = (state_reg == ST_RUN) || (state_reg == ST_SOFTSTART);
  wire fire = running & set_in_i & armed_reg & ~hs_reg;
  wire set_fire = master_reg & running & trig_cmp_i & ~trig_prev_reg & (gap_cnt_reg == 2'h0);
  wire wr = cmd_valid_i & cmd_i.write;
  wire rd = cmd_valid_i & ~cmd_i.write;
  wire rd_ok = rd & master_reg & code_known(cmd_i.code);
  wire [2:0] ss_code = (ss_time_reg[SS_CODE_LSB +: 3] > SS_MAX_CODE) ?
    SS_MAX_CODE : ss_time_reg[SS_CODE_LSB +: 3];
  wire [19:0] ss_target = 20'(SS_BASE_CYCLES) << ss_code;
  wire [10:0] share_scaled = 11'(phase_current_i * phase_count_i);
  wire share_high = share_scaled > total_current_i;
  wire [7:0] on_load = share_high ? ((on_time_base_i > 8'h01) ? on_time_base_i - 8'h01 :
    8'h01) : ((on_time_base_i == 8'hFF) ? 8'hFF : on_time_base_i + 8'h01);
  wire [31:0] ref_prod = vout_cmd_reg * vout_scale_reg;
  wire [21:0] ref_raw = ref_prod[GAIN_FRAC_BITS +: 22];
  wire [9:0] ref_calc = (ref_raw < 22'(REF_MIN_MV)) ? REF_MIN_MV :
    ((ref_raw > 22'(REF_MAX_MV)) ? REF_MAX_MV : ref_raw[9:0]);
  wire fault_seen = master_reg & (state_reg == ST_RUN) & ~power_good_line_i;

  // Start, stop and fault sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: if (ctrl_en_i && role_taken_reg) state_next = ST_PREBIAS;
      ST_PREBIAS: begin
        if (!ctrl_en_i) state_next = ST_DISCHARGE;
        else if (ref_above_fb_i) state_next = ST_SOFTSTART;
      end
      ST_SOFTSTART: begin
        if (!ctrl_en_i) state_next = ST_DISCHARGE;
        else if (ss_cnt_reg >= ss_target - 20'h1) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!ctrl_en_i) state_next = ST_DISCHARGE;
        else if (fault_seen) state_next = ST_FAULT;
      end
      ST_FAULT: if (!ctrl_en_i) state_next = ST_DISCHARGE;
      ST_DISCHARGE: if (fb_below_tenth_i) state_next = ST_OFF;
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_OFF;
      ss_cnt_reg <= 20'h0;
      dis_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ss_cnt_reg <= (state_reg == ST_SOFTSTART) ? ss_cnt_reg + 20'h1 : 20'h0;
      dis_reg <= (state_next == ST_DISCHARGE);
    end
  end

  // Role strap caught on the first edge after release; token arming
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      role_taken_reg <= 1'b0;
      master_reg <= 1'b0;
      armed_reg <= 1'b0;
      token_prev_reg <= 1'b1;
    end else begin
      token_prev_reg <= token_in_i;
      if (!role_taken_reg) begin
        role_taken_reg <= 1'b1;
        master_reg <= token_in_i;
        armed_reg <= token_in_i;
      end else if (token_fall) begin
        armed_reg <= 1'b1;
      end else if (fire) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // Master trigger, spaced by at least the minimum gap
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      set_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      gap_cnt_reg <= 2'h0;
    end else begin
      trig_prev_reg <= trig_cmp_i;
      set_reg <= set_fire;
      if (set_fire) gap_cnt_reg <= 2'(MIN_SET_GAP_CYC - 1);
      else if (gap_cnt_reg != 2'h0) gap_cnt_reg <= gap_cnt_reg - 2'h1;
    end
  end

  // On-time, token pulse and ramp timing
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hs_reg <= 1'b0;
      on_cnt_reg <= 8'h0;
      tok_cnt_reg <= 2'h0;
      ramp_cnt_reg <= 4'h0;
      ls_reg <= 1'b0;
      tok_reg <= 1'b0;
      ramp_reg <= 1'b0;
    end else begin
      if (!running) begin
        hs_reg <= 1'b0;
        on_cnt_reg <= 8'h0;
      end else if (fire) begin
        hs_reg <= 1'b1;
        on_cnt_reg <= on_load - 8'h1;
      end else if (hs_reg && on_cnt_reg == 8'h0) begin
        hs_reg <= 1'b0;
      end else if (hs_reg) begin
        on_cnt_reg <= on_cnt_reg - 8'h1;
      end
      if (fire) tok_cnt_reg <= 2'(TOKEN_PULSE_CYC);
      else if (tok_cnt_reg != 2'h0) tok_cnt_reg <= tok_cnt_reg - 2'h1;
      if (running && set_in_i) ramp_cnt_reg <= 4'(RAMP_RISE_CYC);
      else if (ramp_cnt_reg != 4'h0) ramp_cnt_reg <= ramp_cnt_reg - 4'h1;
      // Flags mirror the counters being nonzero so the pins come straight from flops
      tok_reg <= fire | (tok_cnt_reg > 2'h1);
      ramp_reg <= (running & set_in_i) | (ramp_cnt_reg > 4'h1);
      // Pulse skip lets the low side open at zero crossing instead of sinking current
      ls_reg <= running & ~fire & ~(hs_reg & on_cnt_reg != 8'h0) &
        ~(mode_reg[MODE_SKIP_BIT] & zero_cross_i);
    end
  end

  // Power-good drive: slaves pull low on a local fault, master while not regulating
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pg_oe_reg <= 1'b1;
    end else begin
      pg_oe_reg <= master_reg ? (state_next != ST_RUN) : local_fault_i;
    end
  end

  // Register file
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ss_time_reg <= SOFT_START_RST;
      ramp_sel_reg <= RAMP_AMP_RST;
      valley_reg <= VALLEY_LIMIT_RST;
      mode_reg <= OPERATION_MODE_RST;
      vout_cmd_reg <= VOUT_COMMAND_RST;
      vout_scale_reg <= VOUT_SCALE_RST;
      ref_reg <= REF_DEFAULT_MV;
    end else begin
      if (wr) begin
        case (cmd_i.code)
          REG_SOFT_START_TIME: ss_time_reg <= cmd_i.data;
          REG_RAMP_AMPLITUDE_SELECT: ramp_sel_reg <= cmd_i.data[7:0];
          REG_VALLEY_CURRENT_LIMIT: valley_reg <= cmd_i.data[7:0];
          REG_OPERATION_MODE: mode_reg <= cmd_i.data[7:0];
          REG_VOUT_SCALE_LOOP: vout_scale_reg <= cmd_i.data;
          REG_VOUT_COMMAND: vout_cmd_reg <= cmd_i.data;
          default: ;
        endcase
      end
      // Recomputed every edge so the reference never leaves its clamp, even between writes
      ref_reg <= (vout_cmd_reg == VOUT_COMMAND_RST && vout_scale_reg == VOUT_SCALE_RST) ?
        REF_DEFAULT_MV : ref_calc;
    end
  end

  // Read answers one cycle after the request
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      rsp_valid_reg <= rd;
      rsp_reg.refused <= rd & ~rd_ok;
      if (!rd_ok) rsp_reg.data <= 16'h0;
      else if (cmd_i.code == REG_SOFT_START_TIME) rsp_reg.data <= ss_time_reg;
      else if (cmd_i.code == REG_RAMP_AMPLITUDE_SELECT) rsp_reg.data <= {8'h0, ramp_sel_reg};
      else if (cmd_i.code == REG_VALLEY_CURRENT_LIMIT) rsp_reg.data <= {8'h0, valley_reg};
      else if (cmd_i.code == REG_OPERATION_MODE) rsp_reg.data <= {8'h0, mode_reg};
      else if (cmd_i.code == REG_VOUT_SCALE_LOOP) rsp_reg.data <= vout_scale_reg;
      else rsp_reg.data <= vout_cmd_reg;
    end
  end

  assign token_out_o = tok_reg;
  assign set_out_o = set_reg;
  assign high_side_switch_o = hs_reg;
  assign low_side_switch_o = ls_reg;
  assign discharge_o = dis_reg;
  assign ramp_rise_o = ramp_reg;
  assign ramp_amp_o = ramp_sel_reg[RAMP_AMP_LSB +: 3];
  assign valley_limit_o = valley_reg;
  assign pulse_skip_o = mode_reg[MODE_SKIP_BIT];
  assign freq_sel_o = mode_reg[MODE_FREQ_LSB +: 2];
  assign ref_mv_o = ref_reg;
  assign is_master_o = master_reg;
  assign power_good_line_o = 1'b0;
  assign power_good_line_oe_o = pg_oe_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_o = rsp_reg;

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_fire_start;
    fire ##1 high_side_switch_o;
  endsequence

  a_fire_needs_armed: assert property (high_side_switch_o && !$past(high_side_switch_o)
    |-> $past(armed_reg) && $past(set_in_i)) else $error("switch on without arming");
  a_fire_clears_arm: assert property (fire && !token_fall |=> !armed_reg)
    else $error("arm kept after firing");
  a_token_arms: assert property (role_taken_reg && token_fall |=> armed_reg)
    else $error("token edge did not arm");
  a_token_pulse: assert property (s_fire_start |-> token_out_o [*2] ##1 !token_out_o || fire)
    else $error("token pulse width wrong");
  a_slave_no_set: assert property (!master_reg |-> !set_out_o)
    else $error("slave issued trigger");
  a_ramp_rise: assert property (running && set_in_i |=> ramp_rise_o [*4])
    else $error("ramp rise too short");
  a_slave_read_refused: assert property (rd && !master_reg |=> rsp_valid_o && rsp_o.refused)
    else $error("slave answered read");
  a_prebias_off: assert property (state_reg == ST_PREBIAS |-> !high_side_switch_o &&
    !low_side_switch_o) else $error("switch on during pre-bias");
  a_discharge_off: assert property (state_reg == ST_DISCHARGE |-> discharge_o ##1
    (!high_side_switch_o && !low_side_switch_o)) else $error("discharge sequence broken");
  a_ref_range: assert property (ref_mv_o >= REF_MIN_MV && ref_mv_o <= REF_MAX_MV)
    else $error("reference out of range");
endmodule // multiphase_on_time_sequencer

// ### verif/ring_neighbour_model.sv
// Next phase of the ring: arms on a token fall, fires on the shared trigger, returns the token
module ring_neighbour_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Ring link
  input wire logic start_high_i,
  input wire logic set_i,
  input wire logic token_prev_i,
  output logic token_next_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic armed_reg;
  logic prev_reg;
  logic [2:0] hold_reg;
  logic [1:0] pulse_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
      prev_reg <= 1'b0;
      hold_reg <= 3'h4;
      pulse_reg <= 2'h0;
    end else begin
      prev_reg <= token_prev_i;
      if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
      if (pulse_reg != 2'h0) pulse_reg <= pulse_reg - 2'h1;
      if (prev_reg && !token_prev_i) begin
        armed_reg <= 1'b1;
      end else if (armed_reg && set_i) begin
        armed_reg <= 1'b0;
        pulse_reg <= 2'h2;
      end
    end
  end
  // Pull-up level holds the line only while the ring powers up
  assign token_next_o = (rst_i || hold_reg != 3'h0) ? start_high_i : (pulse_reg != 2'h0);
endmodule // ring_neighbour_model

// ### verif/tb_multiphase_on_time_sequencer.sv
// Self-checking bench for one ring phase with a neighbour model closing the ring
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end
module tb_multiphase_on_time_sequencer;
  import phase_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst, tok_in, tok_out, set_line, trig, ref_above, fb_tenth, ctrl_en;
  logic pg_ext, pg_line, pg_oe, hs, ls, dis, ramp, pskip, is_master, cmd_valid, rsp_valid;
  logic start_high, zc;
  logic [7:0] ph_cur, valley;
  logic [2:0] ramp_amp;
  logic [1:0] freq;
  logic [9:0] ref_mv;
  bus_cmd_t cmd;
  bus_rsp_t rsp;
  int fail_count = 0;
  int tests_run = 0;
  logic [7:0] rc [4] = '{8'h29, 8'h21, 8'h21, 8'h29};
  logic [15:0] rv [4] = '{16'h0400, 16'h02BC, 16'h0226, 16'h0200};
  logic [9:0] rx [4] = '{10'h258, 10'h2A0, 10'h226, 10'h1F4};
  // Open-drain line: the phase pulls low, otherwise the pull-up or a faulty slave sets it
  assign pg_line = pg_oe ? 1'b0 : pg_ext;
  multiphase_on_time_sequencer #(.SS_BASE_CYCLES(4)) dut (
    .clk_i(clk_i), .sys_rst_i(rst), .token_in_i(tok_in), .token_out_o(tok_out),
    .set_in_i(set_line), .set_out_o(set_line), .trig_cmp_i(trig), .ref_above_fb_i(ref_above),
    .fb_below_tenth_i(fb_tenth), .zero_cross_i(zc), .on_time_base_i(8'h05),
    .phase_current_i(ph_cur), .total_current_i(11'h014), .phase_count_i(3'h2),
    .local_fault_i(1'b0), .ctrl_en_i(ctrl_en), .power_good_line_i(pg_line),
    .power_good_line_o(), .power_good_line_oe_o(pg_oe), .high_side_switch_o(hs),
    .low_side_switch_o(ls), .discharge_o(dis), .ramp_rise_o(ramp), .ramp_amp_o(ramp_amp),
    .valley_limit_o(valley), .pulse_skip_o(pskip), .freq_sel_o(freq), .ref_mv_o(ref_mv),
    .is_master_o(is_master), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .rsp_valid_o(rsp_valid),
    .rsp_o(rsp));
  ring_neighbour_model nb (.clk_i(clk_i), .rst_i(rst), .start_high_i(start_high),
    .set_i(set_line), .token_prev_i(tok_out), .token_next_o(tok_in));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd <= {1'b1, c, d};
    @(posedge clk_i);
    cmd_valid <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] d, input logic refd);
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd <= {1'b0, c, 16'h0000};
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    #1;
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp, {refd, d})
  endtask
  // Rising trigger edges one idle cycle apart, then pulse widths counted over a window
  task automatic fire(input int n, input int e_set, input int e_hs, input int e_tok,
                      input int e_rmp);
    int s = 0;
    int h = 0;
    int t = 0;
    int r = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      trig <= (i < 2 * n) && (i % 2 == 0);
      #1;
      s += int'(set_line);
      h += int'(hs);
      t += int'(tok_out);
      r += int'(ramp);
    end
    `CHK(s, e_set)
    `CHK(h, e_hs)
    `CHK(t, e_tok)
    if (e_rmp >= 0) `CHK(r, e_rmp)
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    trig = 1'b0;
    ref_above = 1'b0;
    fb_tenth = 1'b0;
    ctrl_en = 1'b0;
    pg_ext = 1'b1;
    ph_cur = 8'h0A;
    cmd_valid = 1'b0;
    cmd = '0;
    start_high = 1'b1;
    zc = 1'b0;
    repeat (8) @(posedge clk_i);
    rst <= 1'b0;
    wait_cyc(3);
    `CHK(is_master, 1'b1)
    `CHK(ref_mv, 10'h258)
    rd(REG_SOFT_START_TIME, 16'h0000, 1'b0);
    rd(REG_RAMP_AMPLITUDE_SELECT, 16'h0000, 1'b0);
    rd(REG_VALLEY_CURRENT_LIMIT, 16'h0080, 1'b0);
    rd(8'h00, 16'h0000, 1'b1);
    wr(REG_RAMP_AMPLITUDE_SELECT, 16'h000B);
    wr(REG_VALLEY_CURRENT_LIMIT, 16'h0033);
    wr(REG_SOFT_START_TIME, 16'h0001);
    wait_cyc(2);
    `CHK(ramp_amp, 3'h5)
    `CHK(valley, 8'h33)
    rd(REG_RAMP_AMPLITUDE_SELECT, 16'h000B, 1'b0);
    rd(REG_SOFT_START_TIME, 16'h0001, 1'b0);
    for (int f = 0; f < 4; f++) begin
      wr(REG_OPERATION_MODE, 16'(f * 2 + f % 2));
      wait_cyc(2);
      `CHK(freq, 2'(f))
      `CHK(pskip, 1'(f % 2))
    end
    rd(REG_OPERATION_MODE, 16'h0007, 1'b0);
    // Scale is written before the command and again after the second command write
    for (int k = 0; k < 4; k++) begin
      wr(rc[k], rv[k]);
      wait_cyc(3);
      `CHK(ref_mv, rx[k])
    end
    rd(REG_VOUT_COMMAND, 16'h0226, 1'b0);
    rd(REG_VOUT_SCALE_LOOP, 16'h0200, 1'b0);
    ctrl_en <= 1'b1;
    wait_cyc(6);
    `CHK(hs, 1'b0)
    `CHK(ls, 1'b0)
    ref_above <= 1'b1;
    wait_cyc(6);
    `CHK(pg_oe, 1'b1)
    wait_cyc(6);
    `CHK(pg_oe, 1'b0)
    fire(2, 2, 6, 2, 6);
    fire(1, 1, 0, 0, 4);
    fire(1, 1, 6, 2, 4);
    ph_cur <= 8'h1E;
    fire(1, 1, 0, 0, 4);
    fire(1, 1, 4, 2, 4);
    `CHK(ls, 1'b1)
    zc <= 1'b1;
    wait_cyc(2);
    `CHK(ls, 1'b0)
    zc <= 1'b0;
    pg_ext <= 1'b0;
    wait_cyc(3);
    `CHK(pg_oe, 1'b1)
    pg_ext <= 1'b1;
    wait_cyc(3);
    `CHK(pg_oe, 1'b1)
    ctrl_en <= 1'b0;
    wait_cyc(3);
    `CHK(dis, 1'b1)
    `CHK({hs, ls}, 2'b00)
    fb_tenth <= 1'b1;
    wait_cyc(3);
    `CHK(dis, 1'b0)
    start_high <= 1'b0;
    rst <= 1'b1;
    wait_cyc(2);
    rst <= 1'b0;
    wait_cyc(3);
    `CHK(is_master, 1'b0)
    rd(REG_SOFT_START_TIME, 16'h0000, 1'b1);
    wr(REG_RAMP_AMPLITUDE_SELECT, 16'h0004);
    wait_cyc(2);
    `CHK(ramp_amp, 3'h2)
    fire(1, 0, 0, 0, 0);
    end_of_test();
  end
endmodule // tb_multiphase_on_time_sequencer
